/* inc/ulm_pkg.sv */
// Shared constants of the line format, handshake control and line status block.
package ulm_pkg;
  // ----------------------------------------
  // Register offsets on the host bus
  // ----------------------------------------
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IER = 3'h1;
  localparam logic [2:0] OFS_LINE_FORMAT = 3'h3;
  localparam logic [2:0] OFS_HANDSHAKE = 3'h4;
  localparam logic [2:0] OFS_LINE_STATUS = 3'h5;
  // ----------------------------------------
  // Line format field positions
  // ----------------------------------------
  localparam int LF_BANK = 7;
  localparam int LF_BREAK = 6;
  localparam int LF_STICK = 5;
  localparam int LF_SENSE = 4;
  localparam int LF_PAR_ON = 3;
  localparam int LF_STOP = 2;
  localparam int LF_LEN_HI = 1;
  localparam int LF_LEN_LO = 0;
  // ----------------------------------------
  // Handshake control and interrupt enable positions
  // ----------------------------------------
  localparam int HC_LOOP = 4;
  localparam int HC_USER_OUTPUT_2 = 3;
  localparam int HC_USER_OUTPUT_1 = 2;
  localparam int HC_RTS = 1;
  localparam int HC_DTR = 0;
  localparam int IE_LINE = 2;
  localparam int IE_HOLD = 1;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] LINE_FORMAT_RST = 8'h00;
  localparam logic [7:0] HANDSHAKE_RST = 8'h00;
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [15:0] DIVISOR_RST = 16'h0001;
  // ----------------------------------------
  // Timing in sixteenths of a bit, break margin in whole bits
  // ----------------------------------------
  localparam logic [5:0] OVS = 6'h10;
  localparam logic [5:0] STOP_ONE = 6'h10;
  localparam logic [5:0] STOP_ONE_HALF = 6'h18;
  localparam logic [5:0] STOP_TWO = 6'h20;
  localparam logic [3:0] MID_BIT = 4'h7;
  localparam logic [9:0] BREAK_EXTRA_BITS = 10'h003;
  localparam int FIFO_DEPTH = 16;
  localparam int RX_WORD_W = 11;
endpackage

/* verilog/ulm_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module ulm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic flush,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("ulm_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign count = wr_ptr_reg - rd_ptr_reg;
  assign in_ready = (count != (AW + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

/* verilog/ulm_line_ctrl.sv */
// Line format, handshake control and line status logic with serial transmitter and receiver.
`timescale 1ns/100ps
module ulm_line_ctrl #(
  parameter int DEPTH = ulm_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Host register bus
  input wire logic [2:0] host_addr,
  input wire logic host_rd_stb,
  input wire logic host_wr_stb,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  // Mode from the FIFO control logic
  input wire logic fifo_mode_en,
  // Serial line
  input wire logic serial_in,
  output logic serial_out,
  // Handshake pins and status
  output logic rts_on,
  output logic dtr_on,
  input wire logic dsr_in,
  input wire logic cts_in,
  input wire logic ri_in,
  input wire logic dcd_in,
  output logic dsr_stat,
  output logic cts_stat,
  output logic ri_stat,
  output logic dcd_stat,
  // Host interrupt pin
  output logic host_irq_out,
  output logic host_irq_oe_n
);
  if (DEPTH < 2) begin : g_bad_depth
    $error("ulm_line_ctrl: DEPTH must be at least 2");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} ulm_ser_t;

  // ----------------------------------------
  // Registers and bus decode
  // ----------------------------------------
  logic [7:0] line_format_reg;
  logic [7:0] handshake_ctrl_reg;
  logic [7:0] ier_reg;
  logic [15:0] divisor_reg;
  logic [7:0] rdata_reg;
  logic pe_flag_reg, fe_flag_reg, bi_flag_reg, rx_err_sum_reg, ls_irq_reg;
  logic irq_reg, txd_reg;
  logic [3:0] stat_reg;

  wire divisor_bank_select = line_format_reg[ulm_pkg::LF_BANK];
  wire break_on = line_format_reg[ulm_pkg::LF_BREAK];
  wire stick_on = line_format_reg[ulm_pkg::LF_STICK];
  wire parity_sense = line_format_reg[ulm_pkg::LF_SENSE];
  wire parity_on = line_format_reg[ulm_pkg::LF_PAR_ON];
  wire stop_bit_count = line_format_reg[ulm_pkg::LF_STOP];
  wire [1:0] char_len = {line_format_reg[ulm_pkg::LF_LEN_HI], line_format_reg[ulm_pkg::LF_LEN_LO]};
  wire loop_on = handshake_ctrl_reg[ulm_pkg::HC_LOOP];
  wire user_output_2 = handshake_ctrl_reg[ulm_pkg::HC_USER_OUTPUT_2];
  wire user_output_1 = handshake_ctrl_reg[ulm_pkg::HC_USER_OUTPUT_1];

  wire rd_data = host_rd_stb && host_addr == ulm_pkg::OFS_DATA;
  wire wr_data = host_wr_stb && host_addr == ulm_pkg::OFS_DATA;
  wire wr_ier = host_wr_stb && host_addr == ulm_pkg::OFS_IER;
  wire rbr_rd = rd_data && !divisor_bank_select;
  wire thr_wr = wr_data && !divisor_bank_select;
  wire lsr_rd = host_rd_stb && host_addr == ulm_pkg::OFS_LINE_STATUS;
  wire lf_wr = host_wr_stb && host_addr == ulm_pkg::OFS_LINE_FORMAT;
  wire hc_wr = host_wr_stb && host_addr == ulm_pkg::OFS_HANDSHAKE;

  // ----------------------------------------
  // Character format
  // ----------------------------------------
  wire [3:0] nbits = 4'h5 + {2'b00, char_len};
  wire [7:0] len_mask = 8'hff >> (4'h8 - nbits);
  wire [5:0] stop_len = !stop_bit_count ? ulm_pkg::STOP_ONE :
                        (char_len == 2'b00) ? ulm_pkg::STOP_ONE_HALF : ulm_pkg::STOP_TWO;

  function automatic logic parity_of(input logic [7:0] d, input logic [7:0] m, input logic stick,
                                     input logic sense);
    logic x;
    x = ^(d & m);
    if (stick) begin
      parity_of = !sense;
    end else begin
      parity_of = sense ? x : !x;
    end
  endfunction

  // ----------------------------------------
  // Baud divider, one sixteenth-bit enable
  // ----------------------------------------
  logic [15:0] div_cnt_reg;
  wire tick = (div_cnt_reg + 16'h0001 >= divisor_reg);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= tick ? 16'h0000 : div_cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------
  // Transmit path
  // ----------------------------------------
  logic tx_ovalid, tx_iready;
  logic [7:0] tx_odata;
  logic [$clog2(DEPTH):0] tx_count;
  ulm_ser_t tx_st_reg;
  logic [7:0] tx_sh_reg;
  logic [2:0] tx_bit_reg;
  logic [5:0] tx_sub_reg;
  logic tx_line_reg, tx_par_reg;

  // Outside FIFO mode the queue behaves as a single holding buffer.
  wire thr_accept = thr_wr && (fifo_mode_en ? tx_iready : !tx_ovalid);
  wire tx_pop = tick && tx_st_reg == ST_IDLE && tx_ovalid;
  wire tx_bit_end = tick && tx_sub_reg == ulm_pkg::OVS - 6'h01;
  wire holding_empty_flag = !tx_ovalid;
  wire tx_all_empty_flag = !tx_ovalid && tx_st_reg == ST_IDLE;

  ulm_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .flush(1'b0),
    .in_valid(thr_accept),
    .in_ready(tx_iready),
    .in_data(host_wdata),
    .out_valid(tx_ovalid),
    .out_ready(tx_pop),
    .out_data(tx_odata),
    .count(tx_count)
  );

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_st_reg <= ST_IDLE;
      tx_sh_reg <= '0;
      tx_bit_reg <= '0;
      tx_sub_reg <= '0;
      tx_line_reg <= 1'b1;
      tx_par_reg <= 1'b0;
    end else if (tick) begin
      tx_sub_reg <= tx_sub_reg + 6'h01;
      case (tx_st_reg)
        ST_IDLE: begin
          tx_sub_reg <= '0;
          if (tx_ovalid) begin
            tx_st_reg <= ST_START;
            tx_sh_reg <= tx_odata;
            tx_par_reg <= parity_of(tx_odata, len_mask, stick_on, parity_sense);
            tx_line_reg <= 1'b0;
          end
        end
        ST_START: begin
          if (tx_bit_end) begin
            tx_st_reg <= ST_DATA;
            tx_sub_reg <= '0;
            tx_bit_reg <= '0;
            tx_line_reg <= tx_sh_reg[0];
          end
        end
        ST_DATA: begin
          if (tx_bit_end) begin
            tx_sub_reg <= '0;
            tx_sh_reg <= tx_sh_reg >> 1;
            tx_bit_reg <= tx_bit_reg + 3'h1;
            tx_line_reg <= tx_sh_reg[1];
            if ({1'b0, tx_bit_reg} == nbits - 4'h1) begin
              tx_st_reg <= parity_on ? ST_PAR : ST_STOP;
              tx_line_reg <= parity_on ? tx_par_reg : 1'b1;
            end
          end
        end
        ST_PAR: begin
          if (tx_bit_end) begin
            tx_st_reg <= ST_STOP;
            tx_sub_reg <= '0;
            tx_line_reg <= 1'b1;
          end
        end
        ST_STOP: begin
          if (tx_sub_reg == stop_len - 6'h01) begin
            tx_st_reg <= ST_IDLE;
            tx_sub_reg <= '0;
          end
        end
        default: tx_st_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  // Loopback keeps the line pin at mark unless break is on, and feeds the receiver from the transmitter.
  wire rx_line = loop_on ? tx_line_reg : serial_in;
  ulm_ser_t rx_st_reg;
  logic [7:0] rx_sh_reg;
  logic [2:0] rx_bit_reg;
  logic [3:0] rx_sub_reg;
  logic rx_par_reg, head_seen_reg;
  logic [9:0] bk_cnt_reg;
  logic [4:0] err_cnt_reg;
  logic rx_ovalid, rx_iready;
  logic [ulm_pkg::RX_WORD_W-1:0] rx_odata;

  wire rx_mid = tick && rx_sub_reg == 4'hf;
  wire [7:0] rx_word = rx_sh_reg >> (4'h8 - nbits);
  wire rx_pe = parity_on && (rx_par_reg != parity_of(rx_word, len_mask, stick_on, parity_sense));
  wire rx_fe = !rx_line;
  wire rx_done = rx_mid && rx_st_reg == ST_STOP;
  wire rx_push = rx_done && (fifo_mode_en ? rx_iready : !rx_ovalid);
  wire rx_in_err = rx_pe || rx_fe;
  wire rx_head_err = rx_odata[9] || rx_odata[8];
  wire head_take = rx_ovalid && !head_seen_reg;
  wire [9:0] bk_lim = ((10'h001 + {6'h00, nbits} + {9'h000, parity_on} + 10'h001) << 1) + ulm_pkg::BREAK_EXTRA_BITS;
  wire bk_hit = tick && !rx_line && bk_cnt_reg == (bk_lim << 4);

  ulm_fifo #(.WIDTH(ulm_pkg::RX_WORD_W), .DEPTH(DEPTH)) u_rx_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .flush(1'b0),
    .in_valid(rx_push),
    .in_ready(rx_iready),
    .in_data({1'b0, rx_pe, rx_fe, rx_word}),
    .out_valid(rx_ovalid),
    .out_ready(rbr_rd),
    .out_data(rx_odata),
    .count()
  );

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_st_reg <= ST_IDLE;
      rx_sh_reg <= '0;
      rx_bit_reg <= '0;
      rx_sub_reg <= '0;
      rx_par_reg <= 1'b0;
    end else if (tick) begin
      rx_sub_reg <= rx_sub_reg + 4'h1;
      case (rx_st_reg)
        ST_IDLE: begin
          rx_sub_reg <= '0;
          if (!rx_line) begin
            rx_st_reg <= ST_START;
          end
        end
        ST_START: begin
          if (rx_sub_reg == ulm_pkg::MID_BIT) begin
            rx_sub_reg <= '0;
            rx_bit_reg <= '0;
            rx_st_reg <= rx_line ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_mid) begin
            rx_sh_reg <= {rx_line, rx_sh_reg[7:1]};
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if ({1'b0, rx_bit_reg} == nbits - 4'h1) begin
              rx_st_reg <= parity_on ? ST_PAR : ST_STOP;
            end
          end
        end
        ST_PAR: begin
          if (rx_mid) begin
            rx_par_reg <= rx_line;
            rx_st_reg <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (rx_mid) begin
            rx_st_reg <= ST_IDLE;
          end
        end
        default: rx_st_reg <= ST_IDLE;
      endcase
    end
  end

  // Break run length counts sixteenths of continuous space and saturates past the limit.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bk_cnt_reg <= '0;
    end else if (rx_line) begin
      bk_cnt_reg <= '0;
    end else if (tick && bk_cnt_reg != 10'h3ff) begin
      bk_cnt_reg <= bk_cnt_reg + 10'h001;
    end
  end

  // ----------------------------------------
  // Line status flags
  // ----------------------------------------
  wire pe_set = head_take && rx_odata[9];
  wire fe_set = head_take && rx_odata[8];
  wire [4:0] err_cnt_next = err_cnt_reg + {4'h0, rx_push && rx_in_err} - {4'h0, rbr_rd && rx_ovalid && rx_head_err};

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pe_flag_reg <= 1'b0;
      fe_flag_reg <= 1'b0;
      bi_flag_reg <= 1'b0;
      rx_err_sum_reg <= 1'b0;
      ls_irq_reg <= 1'b0;
      head_seen_reg <= 1'b0;
      err_cnt_reg <= '0;
    end else begin
      pe_flag_reg <= pe_set || (pe_flag_reg && !lsr_rd);
      fe_flag_reg <= fe_set || (fe_flag_reg && !lsr_rd);
      bi_flag_reg <= bk_hit || (bi_flag_reg && !lsr_rd);
      rx_err_sum_reg <= fifo_mode_en && (err_cnt_next != '0 || (rx_err_sum_reg && !lsr_rd));
      ls_irq_reg <= pe_set || fe_set || bk_hit || (ls_irq_reg && !lsr_rd);
      head_seen_reg <= rbr_rd ? 1'b0 : (head_seen_reg || rx_ovalid);
      err_cnt_reg <= err_cnt_next;
    end
  end

  wire [7:0] line_status_reg = {rx_err_sum_reg, tx_all_empty_flag, holding_empty_flag, bi_flag_reg,
                                fe_flag_reg, pe_flag_reg, 1'b0, rx_ovalid};

  // ----------------------------------------
  // Register writes, read data and pins
  // ----------------------------------------
  wire [7:0] rd_mux = (host_addr == ulm_pkg::OFS_DATA) ? (divisor_bank_select ? divisor_reg[7:0] : rx_odata[7:0]) :
                      (host_addr == ulm_pkg::OFS_IER) ? (divisor_bank_select ? divisor_reg[15:8] : ier_reg) :
                      (host_addr == ulm_pkg::OFS_LINE_FORMAT) ? line_format_reg :
                      (host_addr == ulm_pkg::OFS_HANDSHAKE) ? handshake_ctrl_reg :
                      (host_addr == ulm_pkg::OFS_LINE_STATUS) ? line_status_reg : 8'h00;
  wire [3:0] stat_src = loop_on ? {user_output_2, user_output_1, handshake_ctrl_reg[ulm_pkg::HC_RTS],
                                   handshake_ctrl_reg[ulm_pkg::HC_DTR]} : {dcd_in, ri_in, cts_in, dsr_in};
  wire irq_next = (ier_reg[ulm_pkg::IE_HOLD] && holding_empty_flag) ||
                  (ier_reg[ulm_pkg::IE_LINE] && ls_irq_reg);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      line_format_reg <= ulm_pkg::LINE_FORMAT_RST;
      handshake_ctrl_reg <= ulm_pkg::HANDSHAKE_RST;
      ier_reg <= ulm_pkg::IER_RST;
      divisor_reg <= ulm_pkg::DIVISOR_RST;
      rdata_reg <= '0;
      stat_reg <= '0;
      irq_reg <= 1'b0;
      txd_reg <= 1'b1;
    end else begin
      if (lf_wr) begin
        line_format_reg <= host_wdata;
      end
      if (hc_wr) begin
        handshake_ctrl_reg <= {3'b000, host_wdata[4:0]};
      end
      if (wr_ier && !divisor_bank_select) begin
        ier_reg <= {4'h0, host_wdata[3:0]};
      end
      if (wr_data && divisor_bank_select) begin
        divisor_reg[7:0] <= host_wdata;
      end
      if (wr_ier && divisor_bank_select) begin
        divisor_reg[15:8] <= host_wdata;
      end
      if (host_rd_stb) begin
        rdata_reg <= rd_mux;
      end
      stat_reg <= stat_src;
      irq_reg <= irq_next;
      txd_reg <= !break_on && (loop_on || tx_line_reg);
    end
  end

  assign host_rdata = rdata_reg;
  assign serial_out = txd_reg;
  assign rts_on = handshake_ctrl_reg[ulm_pkg::HC_RTS];
  assign dtr_on = handshake_ctrl_reg[ulm_pkg::HC_DTR];
  assign {dcd_stat, ri_stat, cts_stat, dsr_stat} = stat_reg;
  assign host_irq_out = irq_reg;
  assign host_irq_oe_n = !user_output_2;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_lsr_read;
    lsr_rd && !pe_set && !fe_set && !bk_hit;
  endsequence
  sequence s_thr_load;
    thr_wr && !tx_ovalid && !tx_pop;
  endsequence

  property p_break_space;
    @(posedge core_clk) disable iff (!rstn) break_on && $past(break_on) |-> !serial_out;
  endproperty
  a_break_space: assert property (p_break_space) else $error("break did not hold line at space");
  property p_irq_enable;
    @(posedge core_clk) disable iff (!rstn) hc_wr |=> host_irq_oe_n == !$past(host_wdata[ulm_pkg::HC_USER_OUTPUT_2]);
  endproperty
  a_irq_enable: assert property (p_irq_enable) else $error("interrupt pin enable mismatch");
  property p_rts_write;
    @(posedge core_clk) disable iff (!rstn) hc_wr |=> rts_on == $past(host_wdata[1]) && dtr_on == $past(host_wdata[0]);
  endproperty
  a_rts_write: assert property (p_rts_write) else $error("handshake output did not follow write");
  property p_tx_all_empty_flag;
    @(posedge core_clk) disable iff (!rstn) (tx_count != '0 || tx_st_reg != ST_IDLE) |-> !line_status_reg[6];
  endproperty
  a_tx_all_empty_flag: assert property (p_tx_all_empty_flag) else $error("transmitter empty while busy");
  property p_holding_empty_flag_clear;
    @(posedge core_clk) disable iff (!rstn) s_thr_load |=> !line_status_reg[5] ##1 !line_status_reg[6];
  endproperty
  a_holding_empty_flag_clear: assert property (p_holding_empty_flag_clear) else $error("holding empty not cleared by write");
  property p_lsr_clear;
    @(posedge core_clk) disable iff (!rstn) s_lsr_read |=> !pe_flag_reg && !fe_flag_reg && !bi_flag_reg;
  endproperty
  a_lsr_clear: assert property (p_lsr_clear) else $error("status read left error flag set");
  property p_sum_nonfifo;
    @(posedge core_clk) disable iff (!rstn) !fifo_mode_en ##1 !fifo_mode_en |-> !line_status_reg[7];
  endproperty
  a_sum_nonfifo: assert property (p_sum_nonfifo) else $error("error summary set outside FIFO mode");
  property p_loop_status;
    @(posedge core_clk) disable iff (!rstn) hc_wr ##1 loop_on |=> dsr_stat == $past(dtr_on, 1) &&
      dcd_stat == $past(user_output_2, 1);
  endproperty
  a_loop_status: assert property (p_loop_status) else $error("loopback status not fed from control");
  property p_line_irq;
    @(posedge core_clk) disable iff (!rstn) ier_reg[ulm_pkg::IE_LINE] && (pe_set || fe_set) |=> ##1 host_irq_out;
  endproperty
  a_line_irq: assert property (p_line_irq) else $error("line status change raised no interrupt");
endmodule

/* tb/ulm_host_model.sv */
// Host processor model driving the register bus of the line control block.
`timescale 1ns/100ps
module ulm_host_model (
  // Clock
  input wire logic core_clk,
  // Register bus
  output logic [2:0] host_addr,
  output logic host_rd_stb,
  output logic host_wr_stb,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata
);
  initial begin
    host_addr = 3'h0;
    host_rd_stb = 1'b0;
    host_wr_stb = 1'b0;
    host_wdata = 8'h00;
  end
  // Released data shows its inverse so a stale value is never mistaken for a fresh one.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    host_wr_stb <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge core_clk);
    host_wr_stb <= 1'b0;
    host_wdata <= ~d;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    host_rd_stb <= 1'b1;
    host_addr <= a;
    @(posedge core_clk);
    host_rd_stb <= 1'b0;
    #1 d = host_rdata;
  endtask
endmodule

/* tb/ulm_line_ctrl_tb.sv */
// Self-checking bench of the line format, handshake control and line status block.
`timescale 1ns/100ps
module ulm_line_ctrl_tb;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic serial_in = 1'b1;
  logic [3:0] hs_in = 4'h5;
  logic fifo_mode = 1'b0;
  logic [2:0] host_addr;
  logic host_rd_stb, host_wr_stb, serial_out, rts_on, dtr_on, host_irq_out, host_irq_oe_n;
  logic dsr_stat, cts_stat, ri_stat, dcd_stat;
  logic [7:0] host_wdata, host_rdata, rd;
  logic [11:0] cap;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  always #4 core_clk = ~core_clk;
  ulm_line_ctrl ulm_line_ctrl_inst (.core_clk(core_clk), .rstn(rstn), .host_addr(host_addr),
    .host_rd_stb(host_rd_stb), .host_wr_stb(host_wr_stb), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .fifo_mode_en(fifo_mode), .serial_in(serial_in), .serial_out(serial_out), .rts_on(rts_on), .dtr_on(dtr_on),
    .dsr_in(hs_in[3]), .cts_in(hs_in[2]), .ri_in(hs_in[1]), .dcd_in(hs_in[0]), .dsr_stat(dsr_stat),
    .cts_stat(cts_stat), .ri_stat(ri_stat), .dcd_stat(dcd_stat), .host_irq_out(host_irq_out),
    .host_irq_oe_n(host_irq_oe_n));
  ulm_host_model ulm_host_model_inst (.core_clk(core_clk), .host_addr(host_addr), .host_rd_stb(host_rd_stb),
    .host_wr_stb(host_wr_stb), .host_wdata(host_wdata), .host_rdata(host_rdata));
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    ulm_host_model_inst.wr(a, d);
  endtask
  task automatic rs(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    ulm_host_model_inst.rd(a, rd);
    chk(rd & m, e);
  endtask
  // With the divisor at one every bit lasts 16 clocks; samples are taken mid-bit.
  task automatic txcap;
    for (int i = 0; i < 200 && serial_out !== 1'b0; i++) @(posedge core_clk);
    repeat (8) @(posedge core_clk);
    for (int b = 0; b < 12; b++) begin
      #1 cap[b] = serial_out;
      repeat (16) @(posedge core_clk);
    end
  endtask
  task automatic rxsend(input logic [23:0] f, input int n);
    for (int b = 0; b < n; b++) begin
      serial_in <= f[b];
      repeat (16) @(posedge core_clk);
    end
    serial_in <= 1'b1;
    repeat (40) @(posedge core_clk);
  endtask
  task automatic t_regs;
    rs(3'h3, 8'hff, 8'h00);
    rs(3'h4, 8'hff, 8'h00);
    rs(3'h5, 8'hfe, 8'h60);
    chk({rts_on, dtr_on, host_irq_oe_n, dsr_stat, cts_stat, ri_stat, dcd_stat}, 12'h015);
    wr(3'h4, 8'h0b);
    repeat (2) @(posedge core_clk);
    chk({rts_on, dtr_on, host_irq_oe_n}, 12'h006);
    rs(3'h4, 8'hff, 8'h0b);
    wr(3'h3, 8'h83);
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h00);
    rs(3'h0, 8'hff, 8'h01);
    wr(3'h3, 8'h43);
    repeat (3) @(posedge core_clk);
    chk(serial_out, 1'b0);
    wr(3'h3, 8'h03);
    repeat (3) @(posedge core_clk);
    chk(serial_out, 1'b1);
    wr(3'h1, 8'h02);
    repeat (2) @(posedge core_clk);
    chk(host_irq_out, 1'b1);
    wr(3'h1, 8'h04);
    repeat (2) @(posedge core_clk);
    chk(host_irq_out, 1'b0);
    $display("registers test done");
  endtask
  task automatic t_tx;
    logic [7:0] lf[5] = '{8'h1a, 8'h0a, 8'h2a, 8'h3a, 8'h03};
    logic [7:0] d[5] = '{8'h54, 8'h54, 8'h54, 8'h54, 8'ha5};
    logic [11:0] fr[5] = '{12'hfa8, 12'hea8, 12'hfa8, 12'hea8, 12'hf4a};
    for (int i = 0; i < 5; i++) begin
      wr(3'h3, lf[i]);
      wr(3'h0, d[i]);
      txcap();
      chk(cap, fr[i]);
      rs(3'h5, 8'h60, 8'h60);
    end
    // Two characters back to back show the stop length as the gap before the second start bit.
    wr(3'h3, 8'h07);
    wr(3'h0, 8'ha5);
    wr(3'h0, 8'ha5);
    txcap();
    chk(cap, 12'h74a);
    rs(3'h5, 8'h60, 8'h20);
    repeat (200) @(posedge core_clk);
    $display("transmit test done");
  endtask
  task automatic t_rx;
    wr(3'h3, 8'h03);
    rxsend(24'h000078, 10);
    chk(host_irq_out, 1'b1);
    rs(3'h5, 8'h1c, 8'h08);
    rs(3'h5, 8'h1c, 8'h00);
    chk(host_irq_out, 1'b0);
    rs(3'h0, 8'hff, 8'h3c);
    wr(3'h3, 8'h1b);
    rxsend(24'h000402, 11);
    rs(3'h5, 8'h1c, 8'h04);
    rs(3'h0, 8'hff, 8'h01);
    wr(3'h3, 8'h07);
    rxsend(24'h0992aa, 20);
    rs(3'h5, 8'h1c, 8'h00);
    rs(3'h0, 8'hff, 8'h55);
    wr(3'h3, 8'h03);
    // Queued mode: a bad character followed by a good one, the error flag travels with its character.
    fifo_mode <= 1'b1;
    rxsend(24'h000078, 10);
    rxsend(24'h0002aa, 10);
    rs(3'h5, 8'h88, 8'h88);
    rs(3'h5, 8'h88, 8'h80);
    rs(3'h0, 8'hff, 8'h3c);
    rs(3'h5, 8'h88, 8'h80);
    rs(3'h5, 8'h88, 8'h00);
    rs(3'h0, 8'hff, 8'h55);
    @(posedge core_clk);
    fifo_mode <= 1'b0;
    rxsend(24'h000000, 25);
    // Let the last character started inside the long space finish while the buffer is still full.
    repeat (40) @(posedge core_clk);
    rs(3'h5, 8'h10, 8'h10);
    rs(3'h5, 8'h10, 8'h00);
    rs(3'h0, 8'hff, 8'h00);
    wr(3'h4, 8'h15);
    repeat (3) @(posedge core_clk);
    chk({dsr_stat, cts_stat, ri_stat, dcd_stat}, 12'h00a);
    wr(3'h0, 8'h5a);
    repeat (250) @(posedge core_clk);
    rs(3'h0, 8'hff, 8'h5a);
    $display("receive test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    wrap_up();
  end
endmodule
